// ==== sse_exec.sv ====
// How it works
// RULE_01: Memory subtract, result to work or memory
// RULE_02: Immediate subtract into working register, flags
// RULE_03: Swap memory nibbles in place, flags kept
// RULE_04: Swapped byte into working register only
// RULE_05: Zero byte skips with dummy cycle
// RULE_06: Load byte to work, skip if zero
// RULE_07: Zero bit skips with dummy cycle
// RULE_08: Current page table word to memory, high
// RULE_09: Last page table word to memory, high
// RULE_10: XOR memory into working register, zero flag
// RULE_11: XOR result stored back to memory
// RULE_12: XOR immediate into working register, zero flag
// RULE_13: Carry means no borrow; zero on result
module sse_exec
   import sse_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic op_valid,
   input wire sse_op_t op_code,
   input wire logic [SSE_MEM_AW-1:0] op_addr,
   input wire logic [2:0] op_bit,
   input wire logic [SSE_DATA_W-1:0] op_imm,
   input wire logic [SSE_DATA_W-1:0] table_pointer,
   input wire logic [SSE_PAGE_W-1:0] current_page,
   input wire logic [SSE_ROM_W-1:0] rom_data,
   input wire logic host_wr_en,
   input wire logic [SSE_MEM_AW-1:0] host_wr_addr,
   input wire logic [SSE_DATA_W-1:0] host_wr_data,
   input wire logic [SSE_MEM_AW-1:0] host_rd_addr,
   output logic op_ready,
   output logic skip_taken,
   output logic [SSE_ROM_AW-1:0] rom_addr,
   output logic [SSE_DATA_W-1:0] host_rd_data,
   output logic [SSE_DATA_W-1:0] working_register,
   output logic [SSE_ROM_HI_W-1:0] table_high_byte_register,
   output logic signed_range_flag,
   output logic null_result_flag,
   output logic nibble_carry_flag,
   output logic borrow_out_flag
);
   sse_alu_if alu_bus();
   sse_state_t state;
   sse_state_t next_state;
   logic [SSE_DATA_W-1:0] mem [SSE_MEM_DEPTH];
   logic [SSE_MEM_AW-1:0] table_dest;

   // Operand fetch and decode
   wire take = clk_en & op_valid & (state == SSE_ST_RUN);
   wire [SSE_DATA_W-1:0] operand = mem[op_addr];
   wire [SSE_DATA_W-1:0] swapped = {operand[SSE_NIB_HI-1:SSE_NIB_LO],
                                    operand[SSE_MSB:SSE_NIB_HI]};
   wire is_sub_mem = (op_code == SSE_OP_SUB_MEM)
                   | (op_code == SSE_OP_SUB_TO_MEM);
   wire is_sub = is_sub_mem | (op_code == SSE_OP_SUB_IMM);
   wire is_xor = (op_code == SSE_OP_XOR_MEM)
               | (op_code == SSE_OP_XOR_TO_MEM)
               | (op_code == SSE_OP_XOR_IMM);
   // RULE_12: immediate operand select
   wire use_imm = (op_code == SSE_OP_SUB_IMM)
                | (op_code == SSE_OP_XOR_IMM);
   wire is_table = (op_code == SSE_OP_TABLE_CUR)
                 | (op_code == SSE_OP_TABLE_LAST);
   wire byte_zero = (operand == 8'h00);
   wire bit_zero = ~operand[op_bit];

   // Skip decision for the three zero tests
   // RULE_05: byte zero test
   wire skip_byte = (op_code == SSE_OP_SKIP_ZERO) & byte_zero;
   // RULE_06: load then test
   wire skip_load = (op_code == SSE_OP_LOAD_SKIP_ZERO) & byte_zero;
   // RULE_07: single bit test
   wire skip_bit = (op_code == SSE_OP_SKIP_BIT_ZERO) & bit_zero;
   wire skip_now = skip_byte | skip_load | skip_bit;

   // Table address: page bits on top of the pointer
   // RULE_09: last page select
   wire [SSE_PAGE_W-1:0] table_page = (op_code == SSE_OP_TABLE_LAST)
                                    ? SSE_LAST_PAGE : current_page;

   assign alu_bus.a = working_register;
   assign alu_bus.b = use_imm ? op_imm : operand;

   sse_alu u_alu (
      .alu(alu_bus.calc)
   );

   // Memory write port select; instruction writes beat host writes
   // RULE_01: difference to memory
   wire wr_sub = take & (op_code == SSE_OP_SUB_TO_MEM);
   // RULE_03: nibble swap in place
   wire wr_swap = take & (op_code == SSE_OP_SWAP_MEM);
   // RULE_11: xor back to memory
   wire wr_xor = take & (op_code == SSE_OP_XOR_TO_MEM);
   // RULE_08: low byte lands in memory
   wire wr_table = clk_en & (state == SSE_ST_TABLE);
   wire core_wr = wr_sub | wr_swap | wr_xor | wr_table;
   wire [SSE_MEM_AW-1:0] wr_addr = wr_table ? table_dest
                                 : (core_wr ? op_addr : host_wr_addr);
   wire [SSE_DATA_W-1:0] wr_data =
      wr_table ? rom_data[SSE_DATA_W-1:0] :
      wr_sub ? alu_bus.diff :
      wr_swap ? swapped :
      wr_xor ? alu_bus.xor_out : host_wr_data;
   // Host writes are lost in a cycle the core also writes
   wire wr_en = core_wr | (clk_en & host_wr_en);

   // Working register source
   wire work_sub = take & ((op_code == SSE_OP_SUB_MEM)
                         | (op_code == SSE_OP_SUB_IMM));
   wire work_xor = take & ((op_code == SSE_OP_XOR_MEM)
                         | (op_code == SSE_OP_XOR_IMM));
   // RULE_04: swap into work
   wire work_swap = take & (op_code == SSE_OP_SWAP_TO_WORK);
   wire work_load = take & (op_code == SSE_OP_LOAD_SKIP_ZERO);
   wire [SSE_DATA_W-1:0] next_work =
      work_sub ? alu_bus.diff :
      work_xor ? alu_bus.xor_out :
      work_swap ? swapped :
      work_load ? operand : working_register;

   // Sequencer: dummy cycle after a skip, wait cycle for table read
   always_comb begin
      next_state = state;
      case (state)
         SSE_ST_RUN: begin
            if (take & skip_now) begin
               next_state = SSE_ST_DUMMY;
            end else if (take & is_table) begin
               next_state = SSE_ST_TABLE;
            end
         end
         SSE_ST_DUMMY: next_state = SSE_ST_RUN;
         SSE_ST_TABLE: next_state = SSE_ST_RUN;
         default: next_state = SSE_ST_RUN;
      endcase
   end

   assign op_ready = (state == SSE_ST_RUN);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SSE_ST_RUN;
         skip_taken <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         // RULE_05: prefetched word discarded
         skip_taken <= take & skip_now;
      end
   end

   // Data memory; reset clears every byte
   generate
      for (genvar i = 0; i < SSE_MEM_DEPTH; i++) begin : g_mem
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               mem[i] <= SSE_MEM_RST;
            end else if (wr_en & (wr_addr == SSE_MEM_AW'(i))) begin
               mem[i] <= wr_data;
            end
         end
      end
   endgenerate

   // Host read port, registered
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         host_rd_data <= SSE_MEM_RST;
      end else if (clk_en) begin
         host_rd_data <= mem[host_rd_addr];
      end
   end

   // Working register, held while clock enable is low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         working_register <= SSE_WORK_RST;
      end else if (clk_en) begin
         working_register <= next_work;
      end
   end

   // Table read: address out, then capture the word
   // RULE_08: high byte captured
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rom_addr <= '0;
         table_dest <= '0;
         table_high_byte_register <= SSE_TABLE_HIGH_BYTE_REGISTER_RST;
      end else if (clk_en) begin
         if (take & is_table) begin
            rom_addr <= {table_page, table_pointer};
            table_dest <= op_addr;
         end
         if (state == SSE_ST_TABLE) begin
            table_high_byte_register <= rom_data[SSE_ROM_W-1:SSE_DATA_W];
         end
      end
   end

   // Flags: subtract sets four, xor only zero, the rest keep all
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         signed_range_flag <= SSE_FLAG_RST;
         null_result_flag <= SSE_FLAG_RST;
         nibble_carry_flag <= SSE_FLAG_RST;
         borrow_out_flag <= SSE_FLAG_RST;
      end else if (take & is_sub) begin
         // RULE_02: four arithmetic flags
         signed_range_flag <= alu_bus.ovf;
         nibble_carry_flag <= alu_bus.half;
         // RULE_13: carry and zero from difference
         borrow_out_flag <= alu_bus.carry;
         null_result_flag <= alu_bus.diff_zero;
      end else if (take & is_xor) begin
         // RULE_10: only zero flag
         null_result_flag <= alu_bus.xor_zero;
      end
   end

endmodule

// ==== sse_pkg.sv ====
package sse_pkg;
   // Data memory and program memory geometry
   localparam int SSE_DATA_W = 8;
   localparam int SSE_MEM_DEPTH = 64;
   localparam int SSE_MEM_AW = 6;
   localparam int SSE_ROM_W = 14;
   localparam int SSE_ROM_AW = 10;
   localparam int SSE_PAGE_W = 2;
   localparam logic [SSE_PAGE_W-1:0] SSE_LAST_PAGE = 2'h3;

   // Field positions
   localparam int SSE_NIB_LO = 0;
   localparam int SSE_NIB_HI = 4;
   localparam int SSE_MSB = 7;
   localparam int SSE_ROM_HI_W = SSE_ROM_W - SSE_DATA_W;

   // Values after reset
   localparam logic [SSE_DATA_W-1:0] SSE_WORK_RST = 8'h00;
   localparam logic [SSE_DATA_W-1:0] SSE_MEM_RST = 8'h00;
   localparam logic [SSE_ROM_HI_W-1:0] SSE_TABLE_HIGH_BYTE_REGISTER_RST = 6'h00;
   localparam logic SSE_FLAG_RST = 1'b0;

   // Cycle counts of one instruction
   localparam int SSE_PLAIN_CYCLES = 1;
   localparam int SSE_SKIP_CYCLES = 2;
   localparam int SSE_TABLE_CYCLES = 2;

   typedef enum logic [3:0] {
      SSE_OP_NONE,
      SSE_OP_SUB_MEM,
      SSE_OP_SUB_TO_MEM,
      SSE_OP_SUB_IMM,
      SSE_OP_SWAP_MEM,
      SSE_OP_SWAP_TO_WORK,
      SSE_OP_SKIP_ZERO,
      SSE_OP_LOAD_SKIP_ZERO,
      SSE_OP_SKIP_BIT_ZERO,
      SSE_OP_TABLE_CUR,
      SSE_OP_TABLE_LAST,
      SSE_OP_XOR_MEM,
      SSE_OP_XOR_TO_MEM,
      SSE_OP_XOR_IMM
   } sse_op_t;

   typedef enum {
      SSE_ST_RUN,
      SSE_ST_DUMMY,
      SSE_ST_TABLE
   } sse_state_t;
endpackage

// ==== sse_alu_if.sv ====
interface sse_alu_if;
   import sse_pkg::*;
   logic [SSE_DATA_W-1:0] a;
   logic [SSE_DATA_W-1:0] b;
   logic [SSE_DATA_W-1:0] diff;
   logic [SSE_DATA_W-1:0] xor_out;
   logic carry;
   logic half;
   logic ovf;
   logic diff_zero;
   logic xor_zero;

   modport calc (
      input a,
      input b,
      output diff,
      output xor_out,
      output carry,
      output half,
      output ovf,
      output diff_zero,
      output xor_zero
   );

   modport user (
      output a,
      output b,
      input diff,
      input xor_out,
      input carry,
      input half,
      input ovf,
      input diff_zero,
      input xor_zero
   );
endinterface

// ==== sse_alu.sv ====
module sse_alu
   import sse_pkg::*;
(
   sse_alu_if.calc alu
);
   logic [SSE_DATA_W:0] full_sum;
   logic [SSE_NIB_HI:0] low_sum;

   // Subtraction as a plus complement plus one, carry means no borrow
   assign full_sum = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
   assign low_sum = {1'b0, alu.a[SSE_NIB_HI-1:SSE_NIB_LO]}
                  + {1'b0, ~alu.b[SSE_NIB_HI-1:SSE_NIB_LO]} + 5'h01;
   assign alu.diff = full_sum[SSE_DATA_W-1:0];
   assign alu.carry = full_sum[SSE_DATA_W];
   assign alu.half = low_sum[SSE_NIB_HI];
   // Signed overflow: operands differ in sign and result sign left a
   assign alu.ovf = (alu.a[SSE_MSB] ^ alu.b[SSE_MSB])
                  & (alu.a[SSE_MSB] ^ full_sum[SSE_MSB]);
   assign alu.diff_zero = (full_sum[SSE_DATA_W-1:0] == 8'h00);

   // Exclusive-OR path
   assign alu.xor_out = alu.a ^ alu.b;
   assign alu.xor_zero = ((alu.a ^ alu.b) == 8'h00);
endmodule

// ==== sse_exec_asserts.sv ====
module sse_exec_chk
   import sse_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic op_valid,
   input wire sse_op_t op_code,
   input wire logic [SSE_DATA_W-1:0] op_imm,
   input wire logic [SSE_DATA_W-1:0] table_pointer,
   input wire logic [SSE_PAGE_W-1:0] current_page,
   input wire logic [SSE_ROM_W-1:0] rom_data,
   input wire logic op_ready,
   input wire logic skip_taken,
   input wire logic [SSE_ROM_AW-1:0] rom_addr,
   input wire logic [SSE_DATA_W-1:0] working_register,
   input wire logic [SSE_ROM_HI_W-1:0] table_high_byte_register,
   input wire logic signed_range_flag,
   input wire logic null_result_flag,
   input wire logic nibble_carry_flag,
   input wire logic borrow_out_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Accepted instruction and the flags that most ops leave alone
   wire logic take = clk_en && op_valid && op_ready;
   wire logic [2:0] keep = {signed_range_flag, nibble_carry_flag,
      borrow_out_flag};
   wire logic [SSE_ROM_HI_W-1:0] rom_hi = rom_data[SSE_ROM_W-1:SSE_DATA_W];
   sequence s_tab;
      take && op_code inside {SSE_OP_TABLE_CUR, SSE_OP_TABLE_LAST};
   endsequence
   a_sub_imm_math: assert property (
      take && op_code == SSE_OP_SUB_IMM |=>
      working_register == $past(working_register) - $past(op_imm))
      else $error("immediate subtract result wrong");
   a_sub_borrow: assert property (
      take && op_code == SSE_OP_SUB_IMM |=>
      borrow_out_flag == ($past(working_register) >= $past(op_imm)))
      else $error("borrow flag wrong");
   a_xor_imm_flags: assert property (
      take && op_code == SSE_OP_XOR_IMM |=>
      working_register == ($past(working_register) ^ $past(op_imm)) &&
      null_result_flag == (working_register == 8'h00) && $stable(keep))
      else $error("immediate xor result or flags wrong");
   a_flags_kept: assert property (
      take && op_code inside {SSE_OP_SWAP_MEM, SSE_OP_SWAP_TO_WORK,
      SSE_OP_SKIP_ZERO, SSE_OP_SKIP_BIT_ZERO, SSE_OP_LOAD_SKIP_ZERO} |=>
      $stable(keep) && $stable(null_result_flag))
      else $error("flags moved on a flag-free op");
   a_skip_dummy: assert property (skip_taken |-> $past(take) &&
      !op_ready ##1 op_ready) else $error("dummy cycle not one cycle");
   a_tab_cur_addr: assert property (
      take && op_code == SSE_OP_TABLE_CUR |=>
      rom_addr == {$past(current_page), $past(table_pointer)})
      else $error("current page table address wrong");
   a_tab_last_addr: assert property (
      take && op_code == SSE_OP_TABLE_LAST |=>
      rom_addr == {SSE_LAST_PAGE, $past(table_pointer)})
      else $error("last page table address wrong");
   a_tab_busy: assert property (s_tab |=> !op_ready ##1 op_ready)
      else $error("table read not two cycles");
   a_tab_high: assert property (s_tab ##1 clk_en |=>
      table_high_byte_register == $past(rom_hi))
      else $error("table high byte wrong");
endmodule

// ==== sse_exec_tb_top.sv ====
module sse_exec_tb_top import sse_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, op_valid = 1'b0;
   logic host_wr_en = 1'b0, sk;
   sse_op_t op_code = SSE_OP_NONE;
   logic [5:0] op_addr = '0, host_wr_addr = '0, host_rd_addr = '0;
   logic [2:0] op_bit = '0;
   logic [7:0] op_imm = '0, table_pointer = '0, host_wr_data = '0;
   logic [1:0] current_page = '0;
   logic [13:0] rom_data;
   logic [9:0] rom_addr;
   logic [7:0] host_rd_data, working_register, rd, w, f;
   logic [5:0] table_high_byte_register;
   logic op_ready, skip_taken, signed_range_flag, null_result_flag;
   logic nibble_carry_flag, borrow_out_flag;
   int fails = 0, checked = 0, n;
   wire logic [7:0] fl = {4'h0, signed_range_flag, null_result_flag,
      nibble_carry_flag, borrow_out_flag};
   logic [7:0] sa [4] = '{8'h50, 8'h30, 8'h80, 8'h44};
   logic [7:0] sb [4] = '{8'h30, 8'h50, 8'h01, 8'h44};
   sse_op_t ko [6] = '{SSE_OP_SKIP_ZERO, SSE_OP_SKIP_ZERO,
      SSE_OP_SKIP_BIT_ZERO, SSE_OP_SKIP_BIT_ZERO, SSE_OP_LOAD_SKIP_ZERO,
      SSE_OP_LOAD_SKIP_ZERO};
   logic [5:0] ka [6] = '{6'h04, 6'h03, 6'h03, 6'h03, 6'h03, 6'h04};
   logic [7:0] kb [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
   logic ks [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
   always #2.5 mclk = ~mclk;
   // Address-dependent ROM so a wrong page shows up in the high byte
   assign rom_data = {rom_addr[9:4], rom_addr[7:0] ^ 8'hA5};
   sse_exec dut (.mclk, .rst_n, .clk_en, .op_valid, .op_code, .op_addr,
      .op_bit, .op_imm, .table_pointer, .current_page, .rom_data,
      .host_wr_en, .host_wr_addr, .host_wr_data, .host_rd_addr, .op_ready,
      .skip_taken, .rom_addr, .host_rd_data, .working_register,
      .table_high_byte_register, .signed_range_flag, .null_result_flag,
      .nibble_carry_flag, .borrow_out_flag);
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // All tasks start and end just after a falling edge
   task automatic wr_mem(logic [5:0] a, logic [7:0] d);
      host_wr_addr = a;
      host_wr_data = d;
      host_wr_en = 1'b1;
      @(negedge mclk);
      host_wr_en = 1'b0;
   endtask
   task automatic rd_mem(logic [5:0] a);
      host_rd_addr = a;
      @(negedge mclk);
      rd = host_rd_data;
   endtask
   // One instruction; n counts cycles with ready low afterwards
   task automatic run(sse_op_t c, logic [5:0] a, logic [7:0] v);
      op_code = c;
      op_addr = a;
      op_imm = v;
      op_bit = v[2:0];
      table_pointer = v;
      op_valid = 1'b1;
      @(negedge mclk);
      op_valid = 1'b0;
      sk = skip_taken;
      n = 0;
      while (op_ready !== 1'b1 && n < 8) begin
         @(negedge mclk);
         n++;
      end
      // Idle edge so a next call never raises valid as this one drops it
      @(negedge mclk);
   endtask
   function automatic logic [7:0] sub_fl(logic [7:0] a, logic [7:0] b);
      logic [8:0] s;
      logic [4:0] l;
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      return {4'h0, (a[7] ^ b[7]) & (s[7] ^ a[7]), s[7:0] == 8'h00, l[4],
         s[8]};
   endfunction
   task automatic tab(sse_op_t c, logic [1:0] pg, logic [7:0] p);
      run(c, 6'h05, p);
      chk("tab_hi", {2'h0, table_high_byte_register}, {pg, p[7:4]});
      rd_mem(6'h05);
      chk("tab_lo", rd, p ^ 8'hA5);
      chk("tab_cyc", 8'(n), 8'h01);
   endtask
   task automatic close_out();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Whole run is about 70 cycles
   initial begin
      #10us;
      fails++;
      close_out();
   end
   initial begin
      w = 8'h00;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      foreach (sa[i]) begin
         run(SSE_OP_XOR_IMM, 6'h00, w ^ sa[i]);
         w = sa[i];
         chk("xor_imm", working_register, w);
         run(SSE_OP_SUB_IMM, 6'h00, sb[i]);
         w = sa[i] - sb[i];
         chk("sub_imm", working_register, w);
         chk("sub_fl", fl, sub_fl(sa[i], sb[i]));
      end
      wr_mem(6'h02, 8'h13);
      run(SSE_OP_XOR_IMM, 6'h00, w ^ 8'h20);
      run(SSE_OP_SUB_MEM, 6'h02, 8'h00);
      chk("sub_mem", working_register, 8'h0D);
      run(SSE_OP_SUB_TO_MEM, 6'h02, 8'h00);
      rd_mem(6'h02);
      chk("sub_to_mem", rd, 8'hFA);
      chk("sub_to_fl", fl, sub_fl(8'h0D, 8'h13));
      chk("sub_to_wr", working_register, 8'h0D);
      wr_mem(6'h03, 8'hA5);
      f = fl;
      run(SSE_OP_SWAP_MEM, 6'h03, 8'h00);
      rd_mem(6'h03);
      chk("swap_mem", rd, 8'h5A);
      run(SSE_OP_SWAP_TO_WORK, 6'h03, 8'h00);
      rd_mem(6'h03);
      chk("swap_keep", rd, 8'h5A);
      chk("swap_wr", working_register, 8'hA5);
      chk("swap_fl", fl, f);
      wr_mem(6'h04, 8'h00);
      foreach (ko[i]) begin
         run(ko[i], ka[i], kb[i]);
         chk("skip", {7'h00, sk}, {7'h00, ks[i]});
         chk("cycles", 8'(n), {7'h00, ks[i]});
      end
      chk("load_skip", working_register, 8'h00);
      current_page = 2'h1;
      tab(SSE_OP_TABLE_CUR, 2'h1, 8'h37);
      tab(SSE_OP_TABLE_LAST, SSE_LAST_PAGE, 8'hC8);
      // xor touches only the zero flag
      wr_mem(6'h07, 8'h3C);
      f = fl;
      run(SSE_OP_XOR_MEM, 6'h07, 8'h00);
      chk("xor_mem", working_register, 8'h3C);
      chk("xor_fl", fl, f & 8'h0B);
      run(SSE_OP_XOR_TO_MEM, 6'h07, 8'h00);
      rd_mem(6'h07);
      chk("xor_to_mem", rd, 8'h00);
      chk("xor_to_fl", fl, (f & 8'h0B) | 8'h04);
      // Clock enable low freezes all state, even with an op offered
      f = fl;
      clk_en = 1'b0;
      run(SSE_OP_XOR_IMM, 6'h00, 8'hFF);
      clk_en = 1'b1;
      chk("freeze_wr", working_register, 8'h3C);
      chk("freeze_fl", fl, f);
      // The empty op code must leave register and flags alone
      run(SSE_OP_NONE, 6'h07, 8'h55);
      chk("none_wr", working_register, 8'h3C);
      chk("none_fl", fl, f);
      close_out();
   end
endmodule
bind sse_exec sse_exec_chk u_chk (.mclk, .rst_n, .clk_en, .op_valid,
   .op_code, .op_imm, .table_pointer, .current_page, .rom_data, .op_ready,
   .skip_taken, .rom_addr, .working_register, .table_high_byte_register,
   .signed_range_flag, .null_result_flag, .nibble_carry_flag,
   .borrow_out_flag);
